/* File: hw/urm_top.sv */
// Serial port register block: Wishbone slave, baud generator, transmitter, flags
//
// The Wishbone register port is this design's own decision.
module urm_top
  import urm_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [5:2] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Serial line
  input wire logic SER_RX_IN,
  output logic SER_TX_OUT,
  // Modem handshake
  input wire logic CTS_N,
  input wire logic DSR_N,
  input wire logic RI_N,
  input wire logic DCD_N,
  output logic DTR_N,
  output logic RTS_N,
  // Interrupt
  output logic IRQ
);

  typedef struct packed {
    logic ack;
    logic [7:0] dat;
    logic [7:0] lcr;
    logic [3:0] ier;
    logic [4:0] mcr;
    logic [7:0] scr;
    logic [15:0] div;
    logic [15:0] bcnt;
    logic tick;
    logic [7:0] receive_buffer;
    logic dr;
    logic oe;
    logic pe;
    logic fe;
    logic bi;
    logic [7:0] thr;
    logic thre;
    urm_ser_t txs;
    logic [7:0] tx_sh;
    logic [2:0] tx_idx;
    logic [5:0] tx_tcnt;
    logic tx_par;
    logic tx_raw;
    logic tx_out;
    logic [3:0] mlev;
    logic [3:0] mdel;
    logic [3:0] evt;
    logic [3:0] mask;
    logic irq;
    logic dtr_n;
    logic rts_n;
  } urm_top_state_t;

  urm_top_state_t s;
  urm_top_state_t n;
  urm_ser_if ser ();

  logic req;
  logic rd;
  logic wr;
  logic dlab;
  logic [3:0] idx;
  logic [7:0] wd;
  logic [7:0] rdata;
  logic [3:0] iir;
  logic [3:0] mnow;
  logic [3:0] ev_set;
  logic [3:0] ev_clr;
  logic [5:0] tx_len;
  logic tx_bit_end;

  // --------------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------------
  assign ser.tick = s.tick;
  assign ser.line = s.mcr[MCR_LOOP] ? s.tx_raw : SER_RX_IN;
  assign ser.len = s.lcr[1:0];
  assign ser.par_en = s.lcr[LCR_PBE];
  assign ser.par_even = s.lcr[LCR_EPE];
  assign ser.par_fixed = s.lcr[LCR_PFIX];

  urm_rx u_rx (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .ser(ser.rx)
  );

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  // Answer one cycle after the request; ack blocks a second take
  assign req = WB_CYC_I & WB_STB_I & ~s.ack;
  assign rd = req & ~WB_WE_I;
  assign wr = req & WB_WE_I & WB_SEL_I[0];
  assign idx = WB_ADR_I;
  assign wd = WB_DAT_I[7:0];
  assign dlab = s.lcr[LCR_DLAB];

  // Loopback ties the modem inputs to the control outputs
  assign mnow = s.mcr[MCR_LOOP] ? {s.mcr[MCR_IRQEN], s.mcr[MCR_LRI], s.mcr[MCR_DTR], s.mcr[MCR_RTS]}
                                : {~DCD_N, ~RI_N, ~DSR_N, ~CTS_N};

  always_comb begin
    if (s.ier[EV_LS] & (s.oe | s.pe | s.fe | s.bi)) begin
      iir = IIR_LS;
    end else if (s.ier[EV_RX] & s.dr) begin
      iir = IIR_RD;
    end else if (s.ier[EV_TX] & s.thre) begin
      iir = IIR_TE;
    end else if (s.ier[EV_MS] & (|s.mdel)) begin
      iir = IIR_MS;
    end else begin
      iir = IIR_NONE;
    end
  end

  always_comb begin
    case (idx)
      IDX_DATA: rdata = dlab ? s.div[7:0] : s.receive_buffer;
      IDX_IER: rdata = dlab ? s.div[15:8] : {4'h0, s.ier};
      IDX_IIR: rdata = {4'h0, 1'b0, iir[2:0]};
      IDX_LCR: rdata = s.lcr;
      IDX_MCR: rdata = {3'h0, s.mcr};
      IDX_LSR: rdata = {1'b0, s.thre & (s.txs == SER_IDLE), s.thre, s.bi, s.fe, s.pe, s.oe, s.dr};
      IDX_MSR: rdata = {s.mlev, s.mdel};
      IDX_SCR: rdata = s.scr;
      IDX_EVT: rdata = {4'h0, s.evt};
      IDX_MASK: rdata = {4'h0, s.mask};
      default: rdata = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    n = s;
    ev_set = 4'h0;
    ev_clr = 4'h0;
    n.ack = req;
    if (rd) begin
      n.dat = rdata;
    end

    // Divisor 0 behaves as 1; one tick every div cycles
    if (s.bcnt <= 16'h0001) begin
      n.bcnt = s.div;
      n.tick = 1'b1;
    end else begin
      n.bcnt = s.bcnt - 16'h0001;
      n.tick = 1'b0;
    end

    // Transmitter runs before the bus so a holding write in the load cycle wins
    tx_len = TICK_BIT;
    if (s.txs == SER_STOP && s.lcr[LCR_MSBE]) begin
      tx_len = (s.lcr[1:0] == 2'h0) ? TICK_STOP15 : TICK_STOP2;
    end
    tx_bit_end = s.tick && (s.tx_tcnt == tx_len - 6'h01);
    if (s.txs != SER_IDLE && s.tick) begin
      n.tx_tcnt = s.tx_tcnt + 6'h01;
    end
    if (tx_bit_end) begin
      n.tx_tcnt = 6'h00;
    end
    case (s.txs)
      SER_IDLE: begin
        if (!s.thre) begin
          n.tx_sh = s.thr;
          n.tx_par = urm_parity(s.thr, s.lcr[1:0], s.lcr[LCR_EPE], s.lcr[LCR_PFIX]);
          n.thre = 1'b1;
          ev_set[EV_TX] = 1'b1;
          n.txs = SER_START;
          n.tx_raw = 1'b0;
          n.tx_tcnt = 6'h00;
        end
      end
      SER_START: begin
        if (tx_bit_end) begin
          n.txs = SER_DATA;
          n.tx_raw = s.tx_sh[0];
          n.tx_idx = 3'h0;
        end
      end
      SER_DATA: begin
        if (tx_bit_end) begin
          if (s.tx_idx == urm_last_bit(s.lcr[1:0])) begin
            n.txs = s.lcr[LCR_PBE] ? SER_PAR : SER_STOP;
            n.tx_raw = s.lcr[LCR_PBE] ? s.tx_par : 1'b1;
          end else begin
            n.tx_sh = {1'b0, s.tx_sh[7:1]};
            n.tx_raw = s.tx_sh[1];
            n.tx_idx = s.tx_idx + 3'h1;
          end
        end
      end
      SER_PAR: begin
        if (tx_bit_end) begin
          n.txs = SER_STOP;
          n.tx_raw = 1'b1;
        end
      end
      SER_STOP: begin
        if (tx_bit_end) begin
          n.txs = SER_IDLE;
        end
      end
      default: begin
        n.txs = SER_IDLE;
        n.tx_raw = 1'b1;
      end
    endcase

    // Register writes; offset 2 is write-only control and stores nothing here
    if (wr) begin
      case (idx)
        IDX_DATA: begin
          if (dlab) begin
            n.div[7:0] = wd;
          end else begin
            n.thr = wd;
            n.thre = 1'b0;
          end
        end
        IDX_IER: begin
          if (dlab) begin
            n.div[15:8] = wd;
          end else begin
            n.ier = wd[3:0];
          end
        end
        IDX_LCR: n.lcr = wd;
        IDX_MCR: n.mcr = wd[4:0];
        IDX_SCR: n.scr = wd;
        IDX_EVT: ev_clr = wd[3:0];
        IDX_MASK: n.mask = wd[3:0];
        default: begin
        end
      endcase
    end

    // Read side effects; a flag set in the same cycle survives
    if (rd) begin
      case (idx)
        IDX_DATA: begin
          if (!dlab) begin
            n.dr = 1'b0;
          end
        end
        IDX_LSR: begin
          n.oe = 1'b0;
          n.pe = 1'b0;
          n.fe = 1'b0;
          n.bi = 1'b0;
        end
        IDX_MSR: n.mdel = 4'h0;
        default: begin
        end
      endcase
    end

    // Received character
    if (ser.done) begin
      n.receive_buffer = ser.data;
      // Overrun only if the old character was not read in this same cycle
      ev_set[EV_LS] = n.dr | ser.par_err | ser.stop_err | ser.silent;
      n.oe = n.oe | n.dr;
      n.dr = 1'b1;
      n.pe = n.pe | ser.par_err;
      n.fe = n.fe | ser.stop_err;
      n.bi = n.bi | ser.silent;
      ev_set[EV_RX] = 1'b1;
    end

    // Modem lines
    n.mlev = mnow;
    n.mdel[MS_CTS] = n.mdel[MS_CTS] | (mnow[MS_CTS] ^ s.mlev[MS_CTS]);
    n.mdel[MS_DSR] = n.mdel[MS_DSR] | (mnow[MS_DSR] ^ s.mlev[MS_DSR]);
    n.mdel[MS_RI] = n.mdel[MS_RI] | (s.mlev[MS_RI] & ~mnow[MS_RI]);
    n.mdel[MS_DCD] = n.mdel[MS_DCD] | (mnow[MS_DCD] ^ s.mlev[MS_DCD]);
    ev_set[EV_MS] = |(mnow ^ s.mlev);

    // Events win over a write-one clear in the same cycle
    n.evt = (s.evt & ~ev_clr) | ev_set;
    n.irq = |(n.evt & n.mask);

    // Break holds the line low; loopback keeps the pins idle
    n.tx_out = n.mcr[MCR_LOOP] | (~n.lcr[LCR_SSE] & n.tx_raw);
    n.dtr_n = n.mcr[MCR_LOOP] | ~n.mcr[MCR_DTR];
    n.rts_n = n.mcr[MCR_LOOP] | ~n.mcr[MCR_RTS];

    if (!RESET_N) begin
      n = '0;
      n.lcr = LCR_RST;
      n.mcr = MCR_RST;
      n.div = DIV_RST;
      n.thre = 1'b1;
      n.tx_raw = 1'b1;
      n.tx_out = 1'b1;
      n.dtr_n = 1'b1;
      n.rts_n = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    s <= n;
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign WB_ACK_O = s.ack;
  assign WB_DAT_O = {24'h000000, s.dat};
  assign SER_TX_OUT = s.tx_out;
  assign DTR_N = s.dtr_n;
  assign RTS_N = s.rts_n;
  assign IRQ = s.irq;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  sequence s_div3_gap;
    !s.tick ##1 !s.tick ##1 s.tick;
  endsequence

  a_divisor_read: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (rd && idx == IDX_DATA && dlab) |=> (s.ack && s.dat == $past(s.div[7:0])))
    else $error("divisor low byte not returned with access bit set");

  a_enable_upper: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (rd && idx == IDX_IER && !dlab) |=> (s.dat == {4'h0, $past(s.ier)}))
    else $error("interrupt enable read back wrong");

  a_tx_lsb_first: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (s.txs == SER_DATA && s.thre) |-> s.tx_raw == s.thr[s.tx_idx])
    else $error("transmit data not sent low bit first");

  a_legacy_zero: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (rd && (idx == IDX_IIR || idx == IDX_LSR)) |=> (s.dat[7] == 1'b0
    && ($past(idx) != IDX_IIR || (s.dat[6] == 1'b0 && s.dat[3] == 1'b0))))
    else $error("FIFO indication bits not zero");

  a_baud_tick: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (s.tick && $past(s.div) == 16'h0003) |=> s_div3_gap)
    else $error("divisor three does not give a tick every third cycle");

  a_status_clear: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (rd && idx == IDX_LSR && !ser.done) |=> ({s.bi, s.fe, s.pe, s.oe} == 4'h0
    && s.dat[4:1] == $past({s.bi, s.fe, s.pe, s.oe})))
    else $error("line status flags not returned then cleared");

  a_shared_write: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (wr && idx == IDX_DATA && !dlab && !ser.done) |=> ($stable(s.receive_buffer) && s.dr == $past(s.dr)))
    else $error("transmit write disturbed the receive buffer");

  a_shared_read: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (rd && (idx == IDX_DATA || idx == IDX_IIR)) |=> $stable(s.thr))
    else $error("read disturbed the transmit holding register");

  a_ack_pulse: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    s.ack |=> !s.ack)
    else $error("acknowledge held longer than one cycle");

endmodule : urm_top

/* File: hw/urm_pkg.sv */
// Constants, types and helpers shared by the serial port modules
package urm_pkg;

  // --------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // --------------------------------------------------------------------
  localparam logic [3:0] IDX_DATA = 4'h0;
  localparam logic [3:0] IDX_IER = 4'h1;
  localparam logic [3:0] IDX_IIR = 4'h2;
  localparam logic [3:0] IDX_LCR = 4'h3;
  localparam logic [3:0] IDX_MCR = 4'h4;
  localparam logic [3:0] IDX_LSR = 4'h5;
  localparam logic [3:0] IDX_MSR = 4'h6;
  localparam logic [3:0] IDX_SCR = 4'h7;
  localparam logic [3:0] IDX_EVT = 4'h8;
  localparam logic [3:0] IDX_MASK = 4'h9;

  // --------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------
  localparam int LCR_DLAB = 7;
  localparam int LCR_SSE = 6;
  localparam int LCR_PFIX = 5;
  localparam int LCR_EPE = 4;
  localparam int LCR_PBE = 3;
  localparam int LCR_MSBE = 2;
  localparam int MCR_LOOP = 4;
  localparam int MCR_IRQEN = 3;
  localparam int MCR_LRI = 2;
  localparam int MCR_RTS = 1;
  localparam int MCR_DTR = 0;
  localparam int EV_RX = 0;
  localparam int EV_TX = 1;
  localparam int EV_LS = 2;
  localparam int EV_MS = 3;
  localparam int MS_CTS = 0;
  localparam int MS_DSR = 1;
  localparam int MS_RI = 2;
  localparam int MS_DCD = 3;

  // --------------------------------------------------------------------
  // Reset values, timing and codes
  // --------------------------------------------------------------------
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [4:0] MCR_RST = 5'h00;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [5:0] TICK_BIT = 6'h10;
  localparam logic [5:0] TICK_HALF = 6'h08;
  localparam logic [5:0] TICK_STOP15 = 6'h18;
  localparam logic [5:0] TICK_STOP2 = 6'h20;
  localparam logic [3:0] IIR_NONE = 4'h1;
  localparam logic [3:0] IIR_LS = 4'h6;
  localparam logic [3:0] IIR_RD = 4'h4;
  localparam logic [3:0] IIR_TE = 4'h2;
  localparam logic [3:0] IIR_MS = 4'h0;

  typedef enum logic [2:0] {SER_IDLE, SER_START, SER_DATA, SER_PAR, SER_STOP} urm_ser_t;

  // Index of the last data bit for a length select
  function automatic logic [2:0] urm_last_bit(input logic [1:0] len);
    return {1'b1, len};
  endfunction : urm_last_bit

  // Right-align a character shifted in from the top
  function automatic logic [7:0] urm_align(input logic [7:0] sh, input logic [1:0] len);
    return sh >> (2'h3 - len);
  endfunction : urm_align

  function automatic logic urm_parity(input logic [7:0] d, input logic [1:0] len,
                                      input logic even, input logic fixed);
    logic [7:0] m;
    m = d & (8'hff >> (2'h3 - len));
    if (fixed) begin
      return ~even;
    end
    return even ? ^m : ~^m;
  endfunction : urm_parity

endpackage : urm_pkg

/* File: hw/urm_ser_if.sv */
// Link between the register block and the serial receiver
interface urm_ser_if;
  logic tick;
  logic line;
  logic [1:0] len;
  logic par_en;
  logic par_even;
  logic par_fixed;
  logic done;
  logic [7:0] data;
  logic par_err;
  logic stop_err;
  logic silent;
  modport rx (input tick, line, len, par_en, par_even, par_fixed,
              output done, data, par_err, stop_err, silent);
  modport ctl (output tick, line, len, par_en, par_even, par_fixed,
               input done, data, par_err, stop_err, silent);
endinterface : urm_ser_if

/* File: hw/urm_rx.sv */
// Serial receiver with sixteen-times oversampling
module urm_rx
  import urm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Receiver link
  urm_ser_if.rx ser
);

  typedef struct packed {
    urm_ser_t st;
    logic [5:0] tcnt;
    logic [2:0] idx;
    logic [7:0] sh;
    logic prev;
    logic silent;
    logic done;
    logic [7:0] data;
    logic perr;
    logic ferr;
    logic brk;
  } urm_rx_state_t;

  urm_rx_state_t s;
  urm_rx_state_t n;
  logic samp;

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    n = s;
    n.done = 1'b0;
    n.prev = ser.line;
    samp = 1'b0;
    if (s.st != SER_IDLE && ser.tick) begin
      n.tcnt = s.tcnt + 6'h01;
      samp = (s.st == SER_START) ? (s.tcnt == TICK_HALF - 6'h01) : (s.tcnt == TICK_BIT - 6'h01);
    end
    if (samp) begin
      n.tcnt = 6'h00;
    end
    case (s.st)
      SER_IDLE: begin
        // Falling edge only, so a held-low line cannot restart a frame
        if (s.prev && !ser.line) begin
          n.st = SER_START;
          n.tcnt = 6'h00;
        end
      end
      SER_START: begin
        if (samp) begin
          n.st = ser.line ? SER_IDLE : SER_DATA;
          n.idx = 3'h0;
          n.silent = 1'b1;
          n.perr = 1'b0;
        end
      end
      SER_DATA: begin
        if (samp) begin
          n.sh = {ser.line, s.sh[7:1]};
          n.silent = s.silent & ~ser.line;
          n.idx = s.idx + 3'h1;
          if (s.idx == urm_last_bit(ser.len)) begin
            n.st = ser.par_en ? SER_PAR : SER_STOP;
          end
        end
      end
      SER_PAR: begin
        if (samp) begin
          n.perr = ser.line != urm_parity(urm_align(s.sh, ser.len), ser.len, ser.par_even, ser.par_fixed);
          n.silent = s.silent & ~ser.line;
          n.st = SER_STOP;
        end
      end
      SER_STOP: begin
        if (samp) begin
          n.ferr = ~ser.line;
          n.brk = s.silent & ~ser.line;
          n.data = urm_align(s.sh, ser.len);
          n.done = 1'b1;
          n.st = SER_IDLE;
        end
      end
      default: begin
        n.st = SER_IDLE;
      end
    endcase
    if (!rst_n) begin
      n = '0;
      n.prev = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    s <= n;
  end

  assign ser.done = s.done;
  assign ser.data = s.data;
  assign ser.par_err = s.perr;
  assign ser.stop_err = s.ferr;
  assign ser.silent = s.brk;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  a_rx_len_five: assert property (@(posedge clk) disable iff (!rst_n)
    (s.done && ser.len == 2'h0) |-> s.data[7:5] == 3'h0)
    else $error("five-bit character has upper bits set");

  a_rx_first_bit: assert property (@(posedge clk) disable iff (!rst_n)
    (samp && s.st == SER_DATA && s.idx == 3'h0) |=> s.sh[7] == $past(ser.line))
    else $error("first data bit not captured as bit zero");

endmodule : urm_rx

/* File: testbench/urm_peer.sv */
// Remote serial device model: frames characters onto the line and captures the design's output
module urm_peer (
  // Clock
  input wire logic clk,
  // Serial lines seen from the remote end
  input wire logic line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;

  int bit_cycles = 16;
  int rx_bits = 8;
  logic [7:0] got = 8'h00;
  int got_n = 0;

  initial line_out = 1'b1;

  // --------------------------------------------------------------------
  // Transmit towards the design; a low stop value makes a framing fault
  // --------------------------------------------------------------------
  task automatic send(input logic [7:0] d, input int nbits, input logic stop_val);
    line_out <= 1'b0;
    repeat (bit_cycles) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      line_out <= d[i];
      repeat (bit_cycles) @(posedge clk);
    end
    line_out <= stop_val;
    repeat (bit_cycles) @(posedge clk);
    // Idle gap so the receiver rearms before the next start bit
    line_out <= 1'b1;
    repeat (2 * bit_cycles) @(posedge clk);
  endtask : send

  // --------------------------------------------------------------------
  // Capture, sampling each bit in its middle
  // --------------------------------------------------------------------
  initial begin
    forever begin
      @(negedge line_in);
      repeat (bit_cycles / 2) @(posedge clk);
      for (int i = 0; i < rx_bits; i++) begin
        repeat (bit_cycles) @(posedge clk);
        got[i] = line_in;
      end
      repeat (bit_cycles) @(posedge clk);
      got_n++;
    end
  end
endmodule : urm_peer

/* File: testbench/tb.sv */
// Self-checking bench for the serial port register block
module tb
  import urm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [5:2] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_i = 32'h00000000;
  logic [31:0] dat_o;
  logic ack, rx_line, tx_line, dtr_n, rts_n, irq;
  logic cts_n = 1'b1;
  logic dsr_n = 1'b1;
  logic ri_n = 1'b1;
  logic dcd_n = 1'b1;
  int mismatches = 0;
  int tests_run = 0;

  urm_top urm_top_inst (.SYS_CLK(sys_clk), .RESET_N(reset_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .SER_RX_IN(rx_line), .SER_TX_OUT(tx_line), .CTS_N(cts_n), .DSR_N(dsr_n),
    .RI_N(ri_n), .DCD_N(dcd_n), .DTR_N(dtr_n), .RTS_N(rts_n), .IRQ(irq));

  urm_peer urm_peer_inst (.clk(sys_clk), .line_in(tx_line), .line_out(rx_line));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  // --------------------------------------------------------------------
  // Reporting and bus tasks
  // --------------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Classic cycle: hold the request until ack is sampled, then drop for a cycle
  task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= idx;
    dat_i <= {24'h000000, wd};
    @(posedge sys_clk);
    while (ack !== 1'b1 && n < 64) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 64) begin
      mismatches++;
      summarize();
    end
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
    @(posedge sys_clk);
  endtask : wb

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, idx, d, r);
  endtask : wr

  task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    wb(1'b0, idx, 8'h00, r);
    check(r, {24'h000000, exp});
  endtask : rd_chk

  // Bounded wait for the remote end to finish capturing a character
  task automatic wait_tx(input int n0);
    int n;
    for (n = 0; n < 3000 && urm_peer_inst.got_n <= n0; n++) @(posedge sys_clk);
    if (n >= 3000) begin
      mismatches++;
      summarize();
    end
  endtask : wait_tx

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd_chk(IDX_LCR, 8'h00);
    rd_chk(IDX_LSR, 8'h60);
    rd_chk(IDX_IIR, 8'h01);
    rd_chk(4'ha, 8'h00);
    wr(IDX_IER, 8'hff);
    rd_chk(IDX_IER, 8'h0f);
    // Divisor latch: low byte 03, high byte 00
    wr(IDX_LCR, 8'h83);
    rd_chk(IDX_DATA, 8'h01);
    wr(IDX_DATA, 8'h03);
    wr(IDX_IER, 8'h00);
    rd_chk(IDX_DATA, 8'h03);
    rd_chk(IDX_IER, 8'h00);
    wr(IDX_LCR, 8'h03);
    rd_chk(IDX_IER, 8'h0f);
    // Transmit at divisor three, then poke the shared write-only offset 2
    urm_peer_inst.bit_cycles = 48;
    wr(IDX_DATA, 8'ha5);
    wr(IDX_IIR, 8'hc7);
    rd_chk(IDX_LSR, 8'h20);
    rd_chk(IDX_IIR, 8'h02);
    wait_tx(0);
    check({24'h000000, urm_peer_inst.got}, 32'h000000a5);
    wr(IDX_LCR, 8'h83);
    wr(IDX_DATA, 8'h01);
    urm_peer_inst.bit_cycles = 16;
    // Receive at every character length
    for (int l = 0; l < 4; l++) begin
      wr(IDX_LCR, {6'h00, l[1:0]});
      urm_peer_inst.send(8'hb6, 5 + l, 1'b1);
      rd_chk(IDX_DATA, 8'(8'hb6 & (8'hff >> (3 - l))));
    end
    // Seven bits with even parity: top bit sent is the parity slot, good then flipped
    wr(IDX_LCR, 8'h1a);
    urm_peer_inst.send(8'h03, 8, 1'b1);
    rd_chk(IDX_LSR, 8'h61);
    rd_chk(IDX_DATA, 8'h03);
    urm_peer_inst.send(8'h83, 8, 1'b1);
    rd_chk(IDX_LSR, 8'h65);
    rd_chk(IDX_LSR, 8'h61);
    rd_chk(IDX_DATA, 8'h03);
    wr(IDX_LCR, 8'h03);
    wr(IDX_EVT, 8'hff);
    rd_chk(IDX_EVT, 8'h00);
    wr(IDX_MASK, 8'h05);
    check({31'h00000000, irq}, 32'h00000000);
    // Silent char with no stop bit, then an unread second char overruns
    urm_peer_inst.send(8'h00, 8, 1'b0);
    urm_peer_inst.send(8'h55, 8, 1'b1);
    check({31'h00000000, irq}, 32'h00000001);
    rd_chk(IDX_EVT, 8'h05);
    rd_chk(IDX_IIR, 8'h06);
    rd_chk(IDX_LSR, 8'h7b);
    rd_chk(IDX_LSR, 8'h61);
    rd_chk(IDX_IIR, 8'h04);
    rd_chk(IDX_DATA, 8'h55);
    wr(IDX_EVT, 8'h05);
    check({31'h00000000, irq}, 32'h00000000);
    // Modem input change shows in status and clears on read
    cts_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd_chk(IDX_MSR, 8'h11);
    rd_chk(IDX_MSR, 8'h10);
    // Handshake outputs follow modem control; loopback idles the pins and feeds the receiver
    wr(IDX_MCR, 8'h03);
    check({30'h00000000, dtr_n, rts_n}, 32'h00000000);
    wr(IDX_MCR, 8'h13);
    check({30'h00000000, dtr_n, rts_n}, 32'h00000003);
    rd_chk(IDX_MSR, 8'h32);
    wr(IDX_DATA, 8'h3c);
    repeat (60) @(posedge sys_clk);
    check({31'h00000000, tx_line}, 32'h00000001);
    repeat (190) @(posedge sys_clk);
    rd_chk(IDX_DATA, 8'h3c);
    // Break forces the line low outside loopback
    wr(IDX_MCR, 8'h00);
    wr(IDX_LCR, 8'h43);
    check({31'h00000000, tx_line}, 32'h00000000);
    wr(IDX_LCR, 8'h03);
    summarize();
  end
endmodule : tb
